/* File: mcm_pkg.sv */
// Constants and types of the command mirror and axis monitor bank
package mcm_pkg;
  localparam int MAX_AXES    = 32;
  localparam int BLOCK_WORDS = 20;
  localparam int MEM_WORDS   = MAX_AXES * BLOCK_WORDS;
  localparam int ADDR_W      = 10;
  localparam int MIX_BITS    = 54;
  localparam int NUM_CMDS    = 9;
  // Word offsets inside one axis block
  localparam logic [4:0] W_CMD_POS   = 5'h00;
  localparam logic [4:0] W_ACT_POS   = 5'h02;
  localparam logic [4:0] W_FERR      = 5'h04;
  localparam logic [4:0] W_MINOR     = 5'h06;
  localparam logic [4:0] W_MAJOR     = 5'h07;
  localparam logic [4:0] W_AMP       = 5'h08;
  localparam logic [4:0] W_RETRAVEL  = 5'h09;
  localparam logic [4:0] W_DOG_TRAV  = 5'h0a;
  localparam logic [4:0] W_PROG      = 5'h0c;
  localparam logic [4:0] W_MCODE     = 5'h0d;
  localparam logic [4:0] W_TORQUE    = 5'h0e;
  localparam logic [4:0] W_CS_PTR    = 5'h0f;
  localparam logic [4:0] W_SPARE     = 5'h10;
  localparam logic [4:0] W_STOP_POS  = 5'h12;
  // Command index order on the command and request vectors
  localparam int C_READY = 0;
  localparam int C_SPEED = 1;
  localparam int C_SERVO = 2;
  localparam int C_MODE  = 3;
  localparam int C_JOG   = 4;
  localparam int C_HW1   = 5;
  localparam int C_HW2   = 6;
  localparam int C_HW3   = 7;
  localparam int C_ERRCL = 8;
  // Mirrored bit positions, counted from the first mixed-area bit
  localparam logic [5:0] MIRROR_POS [NUM_CMDS] = '{6'h00, 6'h28, 6'h2a, 6'h2b, 6'h30, 6'h33, 6'h34, 6'h35, 6'h23};
  localparam logic [15:0]         RDATA_RESET = 16'h0000;
  localparam logic [MIX_BITS-1:0] MIX_RESET   = 54'h0;

  typedef enum logic [1:0] {
    MCM_FETCH_MAIN  = 2'b00,
    MCM_FETCH_START = 2'b01,
    MCM_FETCH_OP    = 2'b10,
    MCM_FETCH_MODE  = 2'b11
  } mcm_fetch_t;
  localparam mcm_fetch_t FETCH_OF [NUM_CMDS] = '{MCM_FETCH_MAIN, MCM_FETCH_START, MCM_FETCH_OP, MCM_FETCH_MODE,
    MCM_FETCH_MAIN, MCM_FETCH_MAIN, MCM_FETCH_MAIN, MCM_FETCH_MAIN, MCM_FETCH_MAIN};

  typedef struct packed {
    logic [31:0] cmd_pos;
    logic [31:0] act_pos;
    logic [31:0] ferr;
    logic [15:0] minor_code;
    logic [15:0] major_code;
    logic [15:0] amp_code;
    logic [15:0] retravel;
    logic [31:0] dog_travel;
    logic [15:0] prog_no;
    logic [15:0] aux_code;
    logic [15:0] torque;
    logic [15:0] cs_ptr;
    logic [31:0] stop_pos;
  } mcm_mon_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } mcm_word_req_t;
endpackage : mcm_pkg

/* File: mcm_bank.sv */
// Command mirror and per-axis monitor word bank
`timescale 1ns/1ps
`default_nettype none
module mcm_bank #(
  parameter int NUM_AXES = 32
) (
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  input  wire logic                           ce,
  input  wire logic                           op_cycle_tick,
  input  wire logic                           main_cycle_tick,
  input  wire logic                           pos_start,
  input  wire logic                           mode_transition,
  input  wire logic [mcm_pkg::NUM_CMDS-1:0]   cmd_bits,
  input  wire logic [mcm_pkg::NUM_CMDS-1:0]   dr_req_valid,
  input  wire logic [mcm_pkg::NUM_CMDS-1:0]   dr_req_value,
  input  wire logic                           mix_wr,
  input  wire logic [5:0]                     mix_idx,
  input  wire logic                           mix_wval,
  input  wire logic [mcm_pkg::MIX_BITS-1:0]   stat_we,
  input  wire logic [mcm_pkg::MIX_BITS-1:0]   stat_val,
  output logic      [mcm_pkg::MIX_BITS-1:0]   mix_bits,
  output logic                                err_hist_clear,
  input  wire logic                           upd_valid,
  input  wire logic [4:0]                     upd_axis,
  input  wire logic                           upd_err_event,
  input  wire logic                           upd_start,
  input  wire logic                           upd_running,
  input  wire mcm_pkg::mcm_mon_t              upd_data,
  input  wire mcm_pkg::mcm_word_req_t         host_req,
  output logic      [15:0]                    host_rdata,
  output logic                                host_rvalid
);
  import mcm_pkg::*;

  logic [15:0]          mem [MEM_WORDS];
  logic [NUM_CMDS-1:0]  fetched_reg;
  logic [NUM_CMDS-1:0]  fetched_next;
  logic [MIX_BITS-1:0]  mix_reg;
  logic [MIX_BITS-1:0]  mix_next;
  logic                 errcl_pulse_reg;
  logic [15:0]          rdata_reg;
  logic                 rvalid_reg;
  logic [NUM_CMDS-1:0]  fetch_now;
  logic [NUM_CMDS-1:0]  rise;
  logic [NUM_CMDS-1:0]  fall;

  function automatic logic [ADDR_W-1:0] word_addr(input logic [4:0] axis, input logic [4:0] word);
    word_addr = ADDR_W'(axis * BLOCK_WORDS + word);
  endfunction

  function automatic logic axis_populated(input logic [ADDR_W-1:0] addr);
    axis_populated = (int'(addr) < NUM_AXES * BLOCK_WORDS);
  endfunction

  function automatic logic fetch_hit(input mcm_fetch_t kind, input logic mn, input logic st, input logic op,
                                     input logic md);
    case (kind)
      MCM_FETCH_MAIN:  fetch_hit = mn;
      MCM_FETCH_START: fetch_hit = st;
      MCM_FETCH_OP:    fetch_hit = op;
      default:         fetch_hit = md;
    endcase
  endfunction

  // Fetch moments of each dedicated command bit
  always_comb begin
    for (int i = 0; i < NUM_CMDS; i++) begin
      fetch_now[i] = fetch_hit(FETCH_OF[i], main_cycle_tick, pos_start, op_cycle_tick, mode_transition);
    end
  end

  assign rise = fetch_now & cmd_bits & ~fetched_reg;
  assign fall = fetch_now & ~cmd_bits & fetched_reg;

  always_comb begin
    fetched_next = fetched_reg;
    mix_next     = mix_reg;
    for (int b = 0; b < MIX_BITS; b++) begin
      if (stat_we[b]) begin
        mix_next[b] = stat_val[b];
      end
    end
    if (mix_wr && (int'(mix_idx) < MIX_BITS)) begin
      mix_next[mix_idx] = mix_wval;
    end
    for (int i = 0; i < NUM_CMDS; i++) begin
      if (fetch_now[i]) begin
        fetched_next[i] = cmd_bits[i];
      end
      if (rise[i] || fall[i]) begin
        mix_next[MIRROR_POS[i]] = rise[i];
      end else if (dr_req_valid[i]) begin
        mix_next[MIRROR_POS[i]] = dr_req_value[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fetched_reg     <= '0;
      mix_reg         <= MIX_RESET;
      errcl_pulse_reg <= 1'b0;
    end else if (ce) begin
      fetched_reg     <= fetched_next;
      mix_reg         <= mix_next;
      errcl_pulse_reg <= mix_next[MIRROR_POS[C_ERRCL]] & ~mix_reg[MIRROR_POS[C_ERRCL]];
    end
  end

  assign mix_bits       = mix_reg;
  assign err_hist_clear = errcl_pulse_reg;

  // Monitor word writes from the motion core and host word port
  logic upd_ok;
  logic host_wr_ok;
  assign upd_ok     = upd_valid && (int'(upd_axis) < NUM_AXES);
  assign host_wr_ok = host_req.wr && (int'(host_req.addr) < MEM_WORDS) && (!axis_populated(host_req.addr) ||
                      (host_req.addr % BLOCK_WORDS == ADDR_W'(W_SPARE)) ||
                      (host_req.addr % BLOCK_WORDS == ADDR_W'(W_SPARE) + 1'b1));

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (host_wr_ok) begin
        mem[host_req.addr] <= host_req.wdata;
      end
      if (upd_ok && op_cycle_tick) begin
        mem[word_addr(upd_axis, W_CMD_POS)]       <= upd_data.cmd_pos[15:0];
        mem[word_addr(upd_axis, W_CMD_POS + 1'b1)] <= upd_data.cmd_pos[31:16];
        mem[word_addr(upd_axis, W_ACT_POS)]       <= upd_data.act_pos[15:0];
        mem[word_addr(upd_axis, W_ACT_POS + 1'b1)] <= upd_data.act_pos[31:16];
        mem[word_addr(upd_axis, W_FERR)]          <= upd_data.ferr[15:0];
        mem[word_addr(upd_axis, W_FERR + 1'b1)]    <= upd_data.ferr[31:16];
        mem[word_addr(upd_axis, W_RETRAVEL)]      <= upd_data.retravel;
        mem[word_addr(upd_axis, W_DOG_TRAV)]      <= upd_data.dog_travel[15:0];
        mem[word_addr(upd_axis, W_DOG_TRAV + 1'b1)] <= upd_data.dog_travel[31:16];
        mem[word_addr(upd_axis, W_MCODE)]         <= upd_data.aux_code;
        mem[word_addr(upd_axis, W_TORQUE)]        <= upd_data.torque;
        mem[word_addr(upd_axis, W_STOP_POS)]      <= upd_data.stop_pos[15:0];
        mem[word_addr(upd_axis, W_STOP_POS + 1'b1)] <= upd_data.stop_pos[31:16];
      end
      if (upd_ok && upd_err_event) begin
        mem[word_addr(upd_axis, W_MINOR)] <= upd_data.minor_code;
        mem[word_addr(upd_axis, W_MAJOR)] <= upd_data.major_code;
      end
      if (upd_ok && main_cycle_tick) begin
        mem[word_addr(upd_axis, W_AMP)] <= upd_data.amp_code;
      end
      if (upd_ok && upd_start) begin
        mem[word_addr(upd_axis, W_PROG)] <= upd_data.prog_no;
      end
      if (upd_ok && (upd_start || upd_running)) begin
        mem[word_addr(upd_axis, W_CS_PTR)] <= upd_data.cs_ptr;
      end
    end
  end

  // Registered read port, one cycle after the request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg  <= RDATA_RESET;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rvalid_reg <= host_req.rd;
      if (host_req.rd) begin
        rdata_reg <= (int'(host_req.addr) < MEM_WORDS) ? mem[host_req.addr] : RDATA_RESET;
      end
    end
  end

  assign host_rdata  = rdata_reg;
  assign host_rvalid = rvalid_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ready_rise_sets: assert property (ce && main_cycle_tick && cmd_bits[C_READY] && !fetched_reg[C_READY]
    |=> mix_bits[MIRROR_POS[C_READY]]) else $error("ready mirror not set");
  a_ready_fall_clears: assert property (ce && main_cycle_tick && !cmd_bits[C_READY] && fetched_reg[C_READY]
    |=> !mix_bits[MIRROR_POS[C_READY]]) else $error("ready mirror not cleared");
  a_dedicated_wins: assert property (ce && op_cycle_tick && dr_req_valid[C_SERVO] &&
    (cmd_bits[C_SERVO] != fetched_reg[C_SERVO]) |=> mix_bits[MIRROR_POS[C_SERVO]] == $past(cmd_bits[C_SERVO]))
    else $error("data request beat command bit");
  a_speed_only_start: assert property (ce && !pos_start && !dr_req_valid[C_SPEED] && !stat_we[MIRROR_POS[C_SPEED]]
    && !(mix_wr && mix_idx == MIRROR_POS[C_SPEED]) |=> $stable(mix_bits[MIRROR_POS[C_SPEED]]))
    else $error("speed mirror moved outside start");
  a_servo_fetch_op: assert property (ce && op_cycle_tick && cmd_bits[C_SERVO] && !fetched_reg[C_SERVO]
    ##1 ce && op_cycle_tick && !cmd_bits[C_SERVO] |=> !mix_bits[MIRROR_POS[C_SERVO]])
    else $error("servo mirror not following");
  a_mode_fetch: assert property (ce && mode_transition && cmd_bits[C_MODE] && !fetched_reg[C_MODE]
    |=> mix_bits[MIRROR_POS[C_MODE]]) else $error("mode mirror not set");
  a_jog_mirror: assert property (ce && main_cycle_tick && cmd_bits[C_JOG] && !fetched_reg[C_JOG]
    |=> mix_bits[MIRROR_POS[C_JOG]]) else $error("jog mirror not set");
  a_errcl_pulse: assert property (ce && $rose(mix_bits[MIRROR_POS[C_ERRCL]]) |-> err_hist_clear)
    else $error("history clear pulse missing");
  a_direct_keeps_cmd: assert property (ce && mix_wr && fetch_now == '0 |=> fetched_reg == $past(fetched_reg))
    else $error("direct write touched command state");
  a_read_latency: assert property (ce && host_req.rd |=> host_rvalid) else $error("read answer late");
  a_ce_freezes_mix: assert property (!ce |=> $stable(mix_bits)) else $error("mix area moved while frozen");
  a_hist_clear_single: assert property (ce && err_hist_clear |=> !err_hist_clear)
    else $error("history clear pulse too long");
endmodule : mcm_bank
`default_nettype wire

/* File: mcm_host.sv */
// Host-side partner issuing word accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module mcm_host (
  input  wire logic                    mclk,
  input  wire logic [15:0]             host_rdata,
  input  wire logic                    host_rvalid,
  output var  mcm_pkg::mcm_word_req_t  host_req
);
  import mcm_pkg::*;
  // Only word accesses here, never command bits
  initial host_req = '0;
  task automatic wr(input logic [9:0] ad, input logic [15:0] d);
    @(posedge mclk);
    host_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge mclk);
    host_req <= '0;
  endtask
  task automatic rd(input logic [9:0] ad, output logic [15:0] d, output logic to);
    int n;
    @(posedge mclk);
    host_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0000};
    @(posedge mclk);
    host_req <= '0;
    n = 0;
    #1;
    while (host_rvalid !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    d = host_rdata;
    to = (n >= 4);
  endtask
endmodule // mcm_host
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the command mirror and monitor bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcm_pkg::*;
  localparam int NA = 8;
  logic          mclk = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic          op_cycle_tick = 1'b0, main_cycle_tick = 1'b0, pos_start = 1'b0, mode_transition = 1'b0;
  logic [8:0]    cmd_bits = '0, dr_req_valid = '0, dr_req_value = '0, fet = '0, nv, dv, dd;
  logic          mix_wr = 1'b0, mix_wval = 1'b0, mw, mv, err_hist_clear, host_rvalid;
  logic [5:0]    mix_idx = '0, mi;
  logic [53:0]   stat_we = '0, stat_val = '0, mix_bits, em = '0, sw, sv;
  logic          upd_valid = 1'b0, upd_err_event = 1'b0, upd_start = 1'b0, upd_running = 1'b0;
  logic [4:0]    upd_axis = '0;
  mcm_mon_t      upd_data = '0, ud;
  mcm_word_req_t host_req;
  logic [15:0]   host_rdata;
  logic [5:0]    pos [9] = '{6'h00, 6'h28, 6'h2a, 6'h2b, 6'h30, 6'h33, 6'h34, 6'h35, 6'h23};
  int            wl [18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 18, 19};
  integer        seed = 32'hd843_d0c1;
  int            n_fail = 0;
  int            comparisons = 0;
  int            a;
  always #25 mclk = ~mclk;
  mcm_bank #(.NUM_AXES(NA)) dut (.mclk, .resetn, .ce, .op_cycle_tick, .main_cycle_tick, .pos_start,
    .mode_transition, .cmd_bits, .dr_req_valid, .dr_req_value, .mix_wr, .mix_idx, .mix_wval, .stat_we,
    .stat_val, .mix_bits, .err_hist_clear, .upd_valid, .upd_axis, .upd_err_event, .upd_start, .upd_running,
    .upd_data, .host_req, .host_rdata, .host_rvalid);
  mcm_host host (.mclk, .host_rdata, .host_rvalid, .host_req);
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction
  function automatic logic [15:0] wexp(mcm_mon_t u, int w);
    case (w)
      0: return u.cmd_pos[15:0];
      1: return u.cmd_pos[31:16];
      2: return u.act_pos[15:0];
      3: return u.act_pos[31:16];
      4: return u.ferr[15:0];
      5: return u.ferr[31:16];
      6: return u.minor_code;
      7: return u.major_code;
      8: return u.amp_code;
      12: return u.prog_no;
      13: return u.aux_code;
      14: return u.torque;
      9: return u.retravel;
      10: return u.dog_travel[15:0];
      11: return u.dog_travel[31:16];
      15: return u.cs_ptr;
      18: return u.stop_pos[15:0];
      default: return u.stop_pos[31:16];
    endcase
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] ex);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic fire();
    @(posedge mclk);
    {main_cycle_tick, pos_start, op_cycle_tick, mode_transition, dr_req_valid, mix_wr, stat_we} <= '0;
    {upd_valid, upd_err_event, upd_start, upd_running} <= '0;
    #1;
  endtask
  task automatic step(input logic [3:0] s);
    logic [53:0] old;
    int c;
    old = em;
    @(posedge mclk);
    {main_cycle_tick, pos_start, op_cycle_tick, mode_transition} <= s;
    {cmd_bits, dr_req_valid, dr_req_value, mix_wr, mix_idx, mix_wval, stat_we, stat_val} <= {nv, dv, dd, mw, mi, mv, sw, sv};
    for (int b = 0; b < 54; b++) if (sw[b]) em[b] = sv[b];
    if (mw) em[mi] = mv;
    for (int i = 0; i < 9; i++) begin
      c = (i == 1) ? 2 : (i == 2) ? 1 : (i == 3) ? 0 : 3;
      if (dv[i]) em[pos[i]] = dd[i];
      if (s[c] && nv[i] !== fet[i]) begin
        em[pos[i]] = nv[i];
        fet[i] = nv[i];
      end
    end
    fire();
    chk(64'(mix_bits), 64'(em));
    chk(64'(err_hist_clear), 64'(em[35] & ~old[35]));
  endtask
  task automatic upd(input logic [4:0] ax);
    for (int i = 0; i < 9; i++) ud[i*32 +: 32] = rnd();
    @(posedge mclk);
    {upd_valid, upd_err_event, upd_start, upd_running, op_cycle_tick, main_cycle_tick} <= '1;
    upd_axis <= ax;
    upd_data <= ud;
    fire();
  endtask
  task automatic rdchk(input logic [9:0] ad, input logic [15:0] ex);
    logic [15:0] d;
    logic to;
    host.rd(ad, d, to);
    if (to) begin
      n_fail++;
      summarize();
    end
    chk(64'(d), 64'(ex));
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    chk({10'h000, mix_bits}, '0);
    chk(64'({err_hist_clear, host_rvalid, host_rdata}), '0);
    @(posedge mclk);
    resetn <= 1'b1;
    $display("test reset done");
    for (int k = 0; k < 40; k++) begin
      {nv, dd, mw, mv} = 20'(rnd());
      dv = 9'(rnd() & rnd() & rnd());
      mi = 6'(rnd() % 54);
      sw = 54'({rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()});
      sv = 54'({rnd(), rnd()});
      step(4'(rnd()));
    end
    sw = '0;
    mw = 1'b0;
    @(posedge mclk);
    ce <= 1'b0;
    {main_cycle_tick, pos_start, op_cycle_tick, mode_transition} <= 4'hf;
    cmd_bits <= ~fet;
    fire();
    chk(64'(mix_bits), 64'(em));
    @(posedge mclk);
    ce <= 1'b1;
    cmd_bits <= fet;
    for (int k = 0; k < 2; k++) begin
      nv = ~fet;
      dv = '1;
      dd = fet;
      step(4'hf);
    end
    dv = '0;
    nv = fet;
    mw = 1'b1;
    mi = 6'h00;
    mv = ~em[0];
    step(4'h1);
    mw = 1'b0;
    step(4'h1);
    $display("test command mirror done");
    a = int'(rnd() % NA);
    upd(5'(a));
    foreach (wl[j]) rdchk(10'(a * 20 + wl[j]), wexp(ud, wl[j]));
    host.wr(10'(a * 20 + 16), 16'h5a5a);
    rdchk(10'(a * 20 + 16), 16'h5a5a);
    host.wr(10'(a * 20), 16'h1234);
    rdchk(10'(a * 20), ud.cmd_pos[15:0]);
    host.wr(10'h0a0, 16'hc3c3);
    upd(5'h08);
    rdchk(10'h0a0, 16'hc3c3);
    rdchk(10'h2bc, 16'h0000);
    $display("test monitor done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
